/* File: hdl/eefe_top.sv */
// Two-wire serial slave front end of a byte-wide nonvolatile memory
`default_nettype none
`include "eefe_regs.svh"

module eefe_top
    import eefe_pkg::*;
#(
    // Type identifier value is arbitrary
    parameter logic [3:0] DEV_TYPE_ID   = `EEFE_DEV_TYPE_DFLT,
    parameter int         WRITE_TIME_NS = `EEFE_WRITE_TIME_NS
) (
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       ce,
    input  wire logic                       scl_i,
    input  wire logic                       sda_i,
    output logic                            sda_o,
    output logic                            sda_oe,
    input  wire logic                       chip_select_pin_0,
    input  wire logic                       chip_select_pin_1,
    input  wire logic                       chip_select_pin_2,
    input  wire logic                       write_protect_input,
    output logic                            mem_rd_strobe,
    output logic [`EEFE_ADDR_BITS-1:0]      mem_rd_addr,
    input  wire logic [7:0]                 mem_rd_data,
    output eefe_pkg::eefe_prog_type         prog,
    output logic                            busy
);
    import eefe_pkg::*;

    // Programming time in cycles, rounded up
    localparam int WRITE_CYCLES =
        (WRITE_TIME_NS + `EEFE_CLK_PERIOD_NS - 1) / `EEFE_CLK_PERIOD_NS;
    localparam logic [`EEFE_TIMER_BITS-1:0] WRITE_LAST =
        `EEFE_TIMER_BITS'(WRITE_CYCLES - 1);
    localparam logic [5:0] PAGE_FULL = 6'(`EEFE_PAGE_BYTES);

    localparam int NPIN = 6;

    logic [NPIN-1:0]  pins_s;
    logic             scl_s;
    logic             sda_s;
    logic [2:0]       cs_s;
    logic             wp_s;
    eefe_bus_ev_type  ev;

    eefe_top_state_type q;
    eefe_top_state_type d;

    // Pins pass two flops before use
    eefe_sync #(
        .WIDTH (NPIN)
    ) u_sync (
        .clk      (clk),
        .reset    (reset),
        .ce       (ce),
        .async_in ({write_protect_input, chip_select_pin_2, chip_select_pin_1,
                    chip_select_pin_0, sda_i, scl_i}),
        .sync_out (pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign cs_s  = pins_s[4:2];
    // pad pull-down keeps a floating pin low
    assign wp_s  = pins_s[5];

    eefe_cond u_cond (
        .clk   (clk),
        .reset (reset),
        .ce    (ce),
        .scl   (scl_s),
        .sda   (sda_s),
        .ev    (ev)
    );

    // Select byte comparison against type and straps
    function automatic logic sel_match(input logic [7:0] b, input logic [2:0] cs);
        sel_match = (b[`EEFE_SEL_TYPE] == DEV_TYPE_ID) && (b[`EEFE_SEL_CS] == cs);
    endfunction

    function automatic logic in_prot(input logic [15:0] a);
        in_prot = (a[`EEFE_PROT_FIELD] == `EEFE_PROT_CODE);
    endfunction

    // Next-state logic
    always_comb begin
        logic [7:0] byte_in;
        logic [4:0] slot;
        byte_in = {q.rx[6:0], ev.sda};
        slot    = q.addr[`EEFE_PAGE_IDX] + q.wcount[4:0];
        d           = q;
        d.rd_strobe = 1'b0;
        d.prog.we   = 1'b0;

        // protect level gathered up to second address byte
        if (q.state == EEFE_SELECT || q.state == EEFE_ADDR_HI ||
            q.state == EEFE_ADDR_LO) begin
            d.wp_seen = q.wp_seen | wp_s;
        end

        if (q.state == EEFE_PROGRAM) begin
            // bus ignored, SDA released while programming
            d.sda_low = 1'b0;
            // skip protected bytes while streaming the page
            if (q.pidx < PAGE_FULL) begin
                d.prog.we   = q.wvalid[q.pidx[4:0]] &
                              ~(q.wp_seen & in_prot(q.addr));
                d.prog.addr = {q.addr[`EEFE_ROW], q.pidx[4:0]};
                d.prog.data = q.pbuf[q.pidx[4:0]];
                d.pidx      = q.pidx + 6'd1;
            end
            d.timer = q.timer + 1'b1;
            if (q.timer == WRITE_LAST) begin
                d.state = EEFE_IDLE;
            end
        end else if (ev.start) begin
            // a start wakes the device from standby
            d.state     = EEFE_SELECT;
            d.bit_cnt   = 4'd0;
            d.sda_low   = 1'b0;
            d.ack_own   = 1'b0;
            d.after_ack = 1'b0;
            d.tx_load   = 1'b0;
            d.wp_seen   = wp_s;
        end else if (ev.stop) begin
            d.sda_low   = 1'b0;
            d.after_ack = 1'b0;
            // only a stop right after the data acknowledge
            if (q.state == EEFE_WDATA && q.after_ack && q.wcount != 6'd0) begin
                d.state                   = EEFE_PROGRAM;
                d.pidx                    = 6'd0;
                d.timer                   = '0;
                d.addr[`EEFE_PAGE_IDX]    = slot;
            end else begin
                d.state = EEFE_IDLE;
            end
        end else if (q.state != EEFE_IDLE && ev.scl_rise) begin
            // ack flag survives the tenth slot's rise
            d.after_ack = q.after_ack & (q.bit_cnt == 4'd0);
            if (q.bit_cnt == `EEFE_ACK_SLOT) begin
                d.bit_cnt   = 4'd0;
                d.after_ack = 1'b1;
                if (q.state == EEFE_RDATA) begin
                    // missing master acknowledge ends the read
                    if (ev.sda) begin
                        d.state = EEFE_IDLE;
                    end else begin
                        d.tx_load = 1'b1;
                    end
                end
            end else begin
                d.rx      = byte_in;
                d.bit_cnt = q.bit_cnt + 4'd1;
                if (q.bit_cnt == `EEFE_LAST_DATA_BIT) begin
                    d.ack_own = 1'b1;
                    unique case (q.state)
                        EEFE_SELECT: begin
                            if (sel_match(byte_in, cs_s)) begin
                                if (byte_in[`EEFE_SEL_RW] == `EEFE_RW_READ) begin
                                    d.state   = EEFE_RDATA;
                                    d.tx_load = 1'b1;
                                end else begin
                                    d.state = EEFE_ADDR_HI;
                                end
                            end else begin
                                d.state   = EEFE_IDLE;
                                d.ack_own = 1'b0;
                            end
                        end
                        EEFE_ADDR_HI: begin
                            d.addr[`EEFE_ADDR_HI] = byte_in;
                            d.state               = EEFE_ADDR_LO;
                        end
                        EEFE_ADDR_LO: begin
                            // address kept for a following read
                            d.addr[`EEFE_ADDR_LO] = byte_in;
                            d.state               = EEFE_WDATA;
                            d.wcount              = 6'd0;
                            d.wvalid              = '0;
                        end
                        EEFE_WDATA: begin
                            // page buffer wraps inside the row
                            d.pbuf[slot]   = byte_in;
                            d.wvalid[slot] = 1'b1;
                            if (q.wcount != PAGE_FULL) begin
                                d.wcount = q.wcount + 6'd1;
                            end
                        end
                        EEFE_RDATA: begin
                            d.ack_own = 1'b0;
                        end
                        default: begin
                            d.ack_own = 1'b0;
                        end
                    endcase
                end
            end
        end else if (q.state != EEFE_IDLE && ev.scl_fall) begin
            if (q.bit_cnt == `EEFE_ACK_SLOT) begin
                d.sda_low = q.ack_own; // Cleared for read data bytes
            end else if (q.bit_cnt == 4'd0 && q.after_ack) begin
                d.sda_low = 1'b0;
                d.ack_own = 1'b0;
                if (q.state == EEFE_RDATA && q.tx_load) begin
                    // Fetch byte and present its first bit
                    d.tx          = {mem_rd_data[6:0], 1'b0};
                    d.sda_low     = ~mem_rd_data[7];
                    d.tx_load     = 1'b0;
                    d.rd_strobe   = 1'b1;
                    d.addr[`EEFE_ADDR_BITS-1:0] =
                        q.addr[`EEFE_ADDR_BITS-1:0] + `EEFE_ADDR_BITS'd1;
                end
            end else if (q.state == EEFE_RDATA && q.bit_cnt != 4'd0) begin
                // present the next data bit after each of bits one to seven
                d.sda_low = ~q.tx[7];
                d.tx      = {q.tx[6:0], 1'b0};
            end
        end

        if (q.state == EEFE_IDLE) begin
            d.sda_low = 1'b0;
        end
    end

    // reset holds everything idle and released
    always_ff @(posedge clk) begin
        if (reset) begin
            q       <= '0;
            q.state <= EEFE_IDLE;
        end else if (ce) begin
            q <= d;
        end
    end

    // Open-drain data pin and array side outputs
    assign sda_o         = 1'b0;
    assign sda_oe        = q.sda_low;
    assign mem_rd_strobe = q.rd_strobe;
    assign mem_rd_addr   = q.addr[`EEFE_ADDR_BITS-1:0];
    assign prog          = q.prog;
    assign busy          = (q.state == EEFE_PROGRAM);
endmodule

`default_nettype wire

/* File: hdl/eefe_regs.svh */
// Constants of the two-wire memory slave front end
`ifndef EEFE_REGS_SVH
`define EEFE_REGS_SVH

`define EEFE_LAST_DATA_BIT  4'd7
`define EEFE_ACK_SLOT       4'd8
`define EEFE_SEL_TYPE       7:4
`define EEFE_SEL_CS         3:1
`define EEFE_SEL_RW         0
`define EEFE_RW_READ        1'b1
`define EEFE_DEV_TYPE_DFLT  4'h5
`define EEFE_PAGE_BYTES     32
`define EEFE_PAGE_IDX       4:0
`define EEFE_ROW            12:5
`define EEFE_PROT_FIELD     12:11
`define EEFE_PROT_CODE      2'b11
`define EEFE_ADDR_BITS      13
`define EEFE_ADDR_HI        15:8
`define EEFE_ADDR_LO        7:0
`define EEFE_CLK_PERIOD_NS  40
`define EEFE_WRITE_TIME_NS  5000000
`define EEFE_TIMER_BITS     24

`endif

/* File: hdl/eefe_pkg.sv */
// Types shared by the memory slave front end
`default_nettype none
`include "eefe_regs.svh"

package eefe_pkg;

    typedef enum logic [2:0] {
        EEFE_IDLE    = 3'h0,
        EEFE_SELECT  = 3'h1,
        EEFE_ADDR_HI = 3'h3,
        EEFE_ADDR_LO = 3'h2,
        EEFE_WDATA   = 3'h6,
        EEFE_PROGRAM = 3'h4,
        EEFE_RDATA   = 3'h7
    } eefe_state_type;

    // Bus events seen on the sampled two-wire link
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } eefe_bus_ev_type;

    // One byte handed to the array during programming
    typedef struct packed {
        logic                       we;
        logic [`EEFE_ADDR_BITS-1:0] addr;
        logic [7:0]                 data;
    } eefe_prog_type;

    typedef struct packed {
        eefe_state_type                       state;
        logic [3:0]                           bit_cnt;
        logic [7:0]                           rx;
        logic [7:0]                           tx;
        logic                                 sda_low;
        logic                                 ack_own;
        logic                                 after_ack;
        logic                                 tx_load;
        logic                                 rd_strobe;
        logic [15:0]                          addr;
        logic                                 wp_seen;
        logic [5:0]                           wcount;
        logic [`EEFE_PAGE_BYTES-1:0]          wvalid;
        logic [`EEFE_PAGE_BYTES-1:0][7:0]     pbuf;
        logic [5:0]                           pidx;
        logic [`EEFE_TIMER_BITS-1:0]          timer;
        eefe_prog_type                        prog;
    } eefe_top_state_type;

endpackage

`default_nettype wire

/* File: hdl/eefe_sync.sv */
// Two-stage synchroniser for pins from outside the clock domain
`default_nettype none

module eefe_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } eefe_sync_state_type;

    eefe_sync_state_type q;
    eefe_sync_state_type d;

    // First stage feeds only the second stage
    always_comb begin
        d    = q;
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign sync_out = q.s2;
endmodule

`default_nettype wire

/* File: hdl/eefe_cond.sv */
// Edge, start and stop detection on the sampled link
`default_nettype none

module eefe_cond
    import eefe_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 ce,
    input  wire logic                 scl,
    input  wire logic                 sda,
    output eefe_pkg::eefe_bus_ev_type ev
);
    typedef struct packed {
        logic scl;
        logic sda;
    } eefe_cond_state_type;

    eefe_cond_state_type q;
    eefe_cond_state_type d;

    // Previous link levels
    always_comb begin
        d     = q;
        d.scl = scl;
        d.sda = sda;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // Clock edges and framing conditions
    always_comb begin
        ev.scl_rise = ~q.scl & scl;
        ev.scl_fall = q.scl & ~scl;
        ev.start    = q.scl & scl & q.sda & ~sda;
        ev.stop     = q.scl & scl & ~q.sda & sda;
        ev.sda      = sda;
    end
endmodule

`default_nettype wire

/* File: tb/eefe_top_props.sv */
// Concurrent checks on the ports of the two-wire memory front end
`default_nettype none
`include "eefe_regs.svh"

module eefe_top_props
    import eefe_pkg::*;
#(
    parameter int WRITE_TIME_NS = 2000
) (
    input wire logic                       clk,
    input wire logic                       reset,
    input wire logic                       scl_i,
    input wire logic                       sda_oe,
    input wire logic                       mem_rd_strobe,
    input wire logic [`EEFE_ADDR_BITS-1:0] mem_rd_addr,
    input wire eefe_pkg::eefe_prog_type    prog,
    input wire logic                       busy
);
    localparam int BUSY_LO = WRITE_TIME_NS / 40 - 4;
    logic [7:0] row_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Row of the previous programmed byte
    always_ff @(posedge clk) begin
        row_q <= prog.addr[12:5];
    end

    sequence s_busy_hold;
        busy throughout (##BUSY_LO 1'b1);
    endsequence
    sequence s_ack_hold;
        sda_oe [*3];
    endsequence

    property p_reset_quiet;
        $fell(reset) |-> !sda_oe && !busy && !prog.we && !mem_rd_strobe
            && mem_rd_addr == 13'h0000;
    endproperty
    property p_busy_quiet;
        busy && $past(busy) |-> !sda_oe && !mem_rd_strobe;
    endproperty
    property p_we_in_cycle;
        prog.we |-> busy && !sda_oe;
    endproperty
    property p_busy_len;
        $rose(busy) |-> s_busy_hold ##[1:8] !busy;
    endproperty
    property p_ack_hold;
        $rose(sda_oe) |=> s_ack_hold;
    endproperty
    property p_drive_in_low;
        $rose(sda_oe) |-> !$past(scl_i, 2);
    endproperty
    property p_strobe_space;
        mem_rd_strobe |=> !mem_rd_strobe [*8];
    endproperty
    property p_same_row;
        prog.we && $past(prog.we) |-> prog.addr[12:5] == row_q;
    endproperty

    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("bus answered during write cycle");
    a_we_in_cycle: assert property (p_we_in_cycle)
        else $error("array write outside write cycle");
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle length wrong");
    a_ack_hold: assert property (p_ack_hold)
        else $error("data line pull too short");
    a_drive_in_low: assert property (p_drive_in_low)
        else $error("data line pulled while clock high");
    a_strobe_space: assert property (p_strobe_space)
        else $error("read strobes too close");
    a_same_row: assert property (p_same_row)
        else $error("page write left its row");
endmodule

bind eefe_top eefe_top_props #(.WRITE_TIME_NS(WRITE_TIME_NS)) u_props (
    .clk(clk), .reset(reset), .scl_i(scl_i), .sda_oe(sda_oe), .busy(busy),
    .mem_rd_strobe(mem_rd_strobe), .mem_rd_addr(mem_rd_addr), .prog(prog)
);

`default_nettype wire

/* File: tb/eefe_master.sv */
// Behavioural two-wire bus master for the memory front end
`default_nettype none

module eefe_master (
    output var logic scl,
    output var logic sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock stands high and data released while idle
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        #120 sda_low = ~b;
        #40 scl = 1'b1;
        #159 r = sda;
        #1;
    endtask

    task automatic start();
        #7 scl = 1'b0;
        #120 sda_low = 1'b0;
        #40 scl = 1'b1;
        #80 sda_low = 1'b1;
        #80;
    endtask

    task automatic stop();
        scl = 1'b0;
        #120 sda_low = 1'b1;
        #40 scl = 1'b1;
        #80 sda_low = 1'b0;
        #320;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

`default_nettype wire

/* File: tb/eefe_top_test.sv */
// Self-checking bench for the two-wire memory front end
`default_nettype none

module eefe_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import eefe_pkg::*;

    localparam logic [3:0] ID = 4'h9; // Type identifier value is arbitrary
    localparam logic [2:0] CS = 3'h5;
    // Rows of protect level, address, data and expected read-back
    localparam logic [32:0] ROWS [6] = '{33'h0_0000_a5_a5, 33'h0_1fff_3c_3c,
        33'h1_1800_77_5a, 33'h1_17ff_0f_0f, 33'h1_e123_81_81, 33'h1_f9ab_c3_f1};
    logic          clk, reset, wp, m_scl, m_low, sda_line, sda_oe, busy;
    logic [12:0]   rd_addr;
    logic [7:0]    rd_data;
    logic [7:0]    mem [8192];
    eefe_prog_type prog;
    int            n_mismatch = 0;
    int            tests_run = 0;

    // Clock source
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Open-drain data line with pull-up
    assign sda_line = (m_low || sda_oe) ? 1'b0 : 1'b1;
    assign rd_data = mem[rd_addr];

    // Array model written by the programming port
    always @(posedge clk) begin
        if (prog.we === 1'b1) mem[prog.addr] <= prog.data;
    end

    eefe_master m (.scl(m_scl), .sda_low(m_low), .sda(sda_line));

    eefe_top #(.DEV_TYPE_ID(ID), .WRITE_TIME_NS(2000)) uut (
        .clk(clk), .reset(reset), .ce(1'b1), .scl_i(m_scl), .sda_i(sda_line), .sda_o(),
        .sda_oe(sda_oe), .chip_select_pin_0(CS[0]), .chip_select_pin_1(CS[1]),
        .chip_select_pin_2(CS[2]), .write_protect_input(wp), .mem_rd_strobe(),
        .mem_rd_addr(rd_addr), .mem_rd_data(rd_data), .prog(prog), .busy(busy)
    );

    function automatic logic [7:0] init_val(input logic [12:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        m.send_byte(d, a);
        chk1(a, exp_ack);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 300) begin
            n_mismatch++;
            close_out();
        end
    endtask

    task automatic finish_wr(input logic p);
        m.stop();
        chk1(busy, p);
        wait_idle();
    endtask

    task automatic wr_addr(input logic [15:0] a);
        m.start();
        send({ID, CS, 1'b0}, 1'b1);
        send(a[15:8], 1'b1);
        send(a[7:0], 1'b1);
    endtask

    task automatic rd_at(input logic [15:0] a, output logic [7:0] d);
        wr_addr(a);
        m.start();
        send({ID, CS, 1'b1}, 1'b1);
        m.recv_byte(1'b0, d);
        m.stop();
    endtask

    // Main sequence
    initial begin
        logic [7:0]  d;
        logic [7:0]  e;
        logic [15:0] a;
        logic        r;
        reset = 1'b1;
        wp = 1'b0;
        for (int i = 0; i < 8192; i++) mem[i] = init_val(13'(i));
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        chk1(sda_oe, 1'b0);
        chk1(busy, 1'b0);
        repeat (4) @(posedge clk);
        done("reset");
        for (int i = 0; i < 6; i++) begin
            {wp, a, d, e} = ROWS[i];
            wr_addr(a);
            send(d, 1'b1);
            finish_wr(1'b1);
            chk8(mem[a[12:0]], e);
            rd_at(a, d);
            chk8(d, e);
            wp = 1'b0;
        end
        done("rows");
        wr_addr(16'h0404);
        for (int i = 1; i < 4; i++) send(8'(8'h11 * i), 1'b1);
        m.stop();
        chk1(busy, 1'b1);
        m.start();
        send({ID, CS, 1'b0}, 1'b0);
        m.stop();
        wait_idle();
        for (int i = 0; i < 3; i++) chk8(mem[1028 + i], 8'(8'h11 * (i + 1)));
        wr_addr(16'h0404);
        m.start();
        send({ID, CS, 1'b1}, 1'b1);
        m.recv_byte(1'b1, d);
        chk8(d, 8'h11);
        m.recv_byte(1'b0, d);
        chk8(d, 8'h22);
        m.stop();
        done("page");
        for (int i = 0; i < 4; i++) begin
            m.start();
            send(i < 3 ? {ID, CS ^ 3'(1 << i), 1'b0} : {ID ^ 4'h1, CS, 1'b0}, 1'b0);
            send(8'h00, 1'b0);
            m.stop();
        end
        chk1(busy, 1'b0);
        done("select");
        wr_addr(16'h0010);
        send(8'h99, 1'b1);
        for (int i = 0; i < 4; i++) m.bit_io(1'b0, r);
        finish_wr(1'b0);
        chk8(mem[16], init_val(13'h0010));
        wr_addr(16'h0011);
        for (int i = 0; i < 3; i++) m.bit_io(1'b0, r);
        m.start();
        send({ID, CS, 1'b1}, 1'b1);
        m.recv_byte(1'b0, d);
        m.stop();
        chk8(d, init_val(13'h0011));
        done("abort");
        @(posedge clk);
        #1 reset = 1'b1;
        m.start();
        send({ID, CS, 1'b0}, 1'b0);
        m.stop();
        @(posedge clk);
        #1 reset = 1'b0;
        repeat (4) @(posedge clk);
        m.start();
        send({ID, CS, 1'b1}, 1'b1);
        m.recv_byte(1'b0, d);
        m.stop();
        chk8(d, 8'ha5);
        done("second reset");
        close_out();
    end
endmodule

`default_nettype wire
